/* File: design/dcep_pkg.sv */
package dcep_pkg;

   localparam logic [8:0] IDX_CACHE = 9'h020;
   localparam logic [8:0] IDX_SEG   = 9'h021;
   localparam logic [8:0] IDX_RECOV = 9'h024;
   localparam logic [8:0] IDX_RETRY = 9'h025;
   localparam logic [8:0] IDX_DRIVE = 9'h027;
   localparam logic [8:0] IDX_LAST  = 9'h1ff;

   localparam int B_CACHE    = 0;
   localparam int B_PREFETCH = 1;
   localparam int B_SKIPCOR  = 0;
   localparam int B_IMMECC   = 3;
   localparam int B_RCONT    = 4;
   localparam int B_RDREALOC = 6;
   localparam int B_WRREALOC = 7;
   localparam int B_REUNC    = 1;
   localparam int B_WBB      = 2;
   localparam int B_AGEO     = 5;
   localparam int B_AREAD    = 6;

   // Only defined bits survive a page load; everything else reads as zero.
   localparam logic [7:0] MASK_CACHE = 8'h03;
   localparam logic [7:0] MASK_RECOV = 8'hd9;
   localparam logic [7:0] MASK_DRIVE = 8'h66;

   localparam logic [7:0] RST_CACHE = 8'h03;
   localparam logic [7:0] RST_SEG   = 8'h01;
   localparam logic [7:0] RST_RECOV = 8'hc0;
   localparam logic [7:0] RST_RETRY = 8'h08;
   localparam logic [7:0] RST_DRIVE = 8'h26;
   localparam logic [7:0] ECC_SPAN  = 8'h10;

   localparam int E_BBK  = 7;
   localparam int E_UNC  = 6;
   localparam int E_IDNF = 4;
   localparam int E_ABRT = 2;
   localparam int E_TK0  = 1;
   localparam int E_AMNF = 0;
   localparam int S_DRDY = 6;
   localparam int S_DWF  = 5;
   localparam int S_DSC  = 4;
   localparam int S_CORR = 2;
   localparam int S_ERR  = 0;

   typedef enum logic [2:0] {
      CLS_READ    = 3'b000,
      CLS_WRITE   = 3'b001,
      CLS_RECAL   = 3'b010,
      CLS_DIAG    = 3'b011,
      CLS_OTHER   = 3'b100,
      CLS_INVALID = 3'b101
   } dcep_cls_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CHECK = 3'b001,
      ST_HOLD  = 3'b010,
      ST_EXEC  = 3'b011,
      ST_DONE  = 3'b100
   } dcep_state_t;

   // Error and status bits that each command class may report.
   function automatic logic [15:0] dcep_masks(input dcep_cls_t cls);
      case (cls)
         CLS_READ:  dcep_masks = {8'hd5, 8'h75};
         CLS_WRITE: dcep_masks = {8'h94, 8'h71};
         CLS_RECAL: dcep_masks = {8'h06, 8'h71};
         CLS_DIAG:  dcep_masks = {8'h00, 8'h01};
         default:   dcep_masks = {8'h04, 8'h71};
      endcase
   endfunction : dcep_masks

endpackage : dcep_pkg

/* File: design/dcep_page_capture.sv */
`timescale 1ns/1ps
module dcep_page_capture
   import dcep_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       page_start,
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   input  wire logic       key_ok,
   output logic            page_done,
   output logic            page_ok,
   output logic [7:0]      cache_byte,
   output logic [7:0]      seg_byte,
   output logic [7:0]      recov_byte,
   output logic [7:0]      retry_byte,
   output logic [7:0]      drive_byte
);

   logic [8:0] idx_reg;
   logic       active_reg;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         idx_reg    <= 9'h000;
         active_reg <= 1'b0;
         page_done  <= 1'b0;
         page_ok    <= 1'b0;
      end else begin
         page_done <= 1'b0;
         if (page_start) begin
            idx_reg    <= 9'h000;
            active_reg <= 1'b1;
         end else if (active_reg && byte_valid) begin
            if (idx_reg == IDX_LAST) begin
               active_reg <= 1'b0;
               page_done  <= 1'b1;
               page_ok    <= key_ok;
            end else begin
               idx_reg <= idx_reg + 9'h001;
            end
         end
      end
   end

   // Reserved bits are dropped here so a sloppy page cannot set them.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cache_byte <= RST_CACHE;
         seg_byte   <= RST_SEG;
         recov_byte <= RST_RECOV;
         retry_byte <= RST_RETRY;
         drive_byte <= RST_DRIVE;
      end else if (active_reg && byte_valid && !page_start) begin
         if (idx_reg == IDX_CACHE) begin
            cache_byte <= byte_data & MASK_CACHE;
         end else if (idx_reg == IDX_SEG) begin
            seg_byte <= byte_data;
         end else if (idx_reg == IDX_RECOV) begin
            recov_byte <= byte_data & MASK_RECOV;
         end else if (idx_reg == IDX_RETRY) begin
            retry_byte <= byte_data;
         end else if (idx_reg == IDX_DRIVE) begin
            drive_byte <= byte_data & MASK_DRIVE;
         end
      end
   end

endmodule : dcep_page_capture

/* File: design/dcep_config_policy.sv */
// Behaviour
// - Prefetch only while both prefetch and cache bits are set; both reset to one.
// - Cache on every read when caching is on, else buffer only.
// - Segment count comes from page byte 33, default one.
// - Reallocate a block that fails writing when write reallocation is on.
// - Reallocate after equal nonzero syndromes twice when read reallocation is on, unless read continuous.
// - Read continuous: no recovery, errors ignored are not posted.
// - Immediate correction on repeated correctable syndrome; reread otherwise.
// - Skip correction delivers data raw unless read continuous.
// - Otherwise correct when possible; uncorrectable data goes raw after rereads.
// - Data errors are posted whatever the skip correction bit.
// - Reread up to the retry count of byte 37, default eight.
// - Correction span reads as fixed sixteen.
// - Auto read follows byte 39 bit 6, default off.
// - Automatic geometry update follows its bit, default on.
// - Write-back: a write completes once host data is buffered.
// - Non-write commands wait until buffered write data is flushed.
// - A following write accepts data while flushing continues.
// - Reallocate uncorrectable sectors when the read reallocation and reallocate-uncorrectable bits are set.
// - Check each command for abort conditions before executing.
// - Stop a command at the first new error.
// - Read commands report only their permitted error and status bits.
// - Write, recalibrate, diagnostics and invalid codes have restricted reports.
`timescale 1ns/1ps
module dcep_config_policy
   import dcep_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        page_start,
   input  wire logic        page_byte_valid,
   input  wire logic [7:0]  page_byte,
   input  wire logic        page_key_ok,
   input  wire logic        cmd_valid,
   input  wire dcep_cls_t   cmd_class,
   input  wire logic        cmd_param_ok,
   output logic             cmd_ready,
   output logic             cmd_done,
   output logic [7:0]       error_out,
   output logic [7:0]       status_out,
   input  wire logic        drive_ready,
   input  wire logic        seek_complete,
   input  wire logic        diag_fail,
   input  wire logic        buf_pending,
   input  wire logic        host_data_all_in,
   input  wire logic        media_done,
   input  wire logic        media_data_err,
   input  wire logic [15:0] media_syndrome,
   input  wire logic        media_correctable,
   input  wire logic        media_sector_ok,
   input  wire logic        media_write_fault,
   input  wire logic        media_idnf,
   input  wire logic        media_amnf,
   input  wire logic        media_bbk,
   input  wire logic        media_tk0_fail,
   output logic             host_data_accept,
   output logic             reread_req,
   output logic             correct_req,
   output logic             deliver_raw,
   output logic             realloc_req,
   output logic             cache_on,
   output logic             prefetch_on,
   output logic [7:0]       segment_count,
   output logic [7:0]       retry_limit,
   output logic [7:0]       ecc_span,
   output logic             auto_read_on,
   output logic             auto_geometry_on,
   output logic             write_back_on,
   output logic             read_continuous_on
);

   dcep_state_t state_reg;
   dcep_state_t state_next;
   dcep_cls_t   cls_reg;
   logic        param_ok_reg;
   logic [7:0]  cache_reg;
   logic [7:0]  seg_reg;
   logic [7:0]  recov_reg;
   logic [7:0]  retry_reg;
   logic [7:0]  drive_reg;
   logic [7:0]  pg_cache;
   logic [7:0]  pg_seg;
   logic [7:0]  pg_recov;
   logic [7:0]  pg_retry;
   logic [7:0]  pg_drive;
   logic        pg_done;
   logic        pg_ok;
   logic [7:0]  retry_cnt_reg;
   logic [15:0] last_syn_reg;
   logic        syn_valid_reg;
   logic [7:0]  err_acc_reg;
   logic        corr_acc_reg;
   logic        dwf_acc_reg;
   logic        eff_skip;
   logic        eff_imm;
   logic        eff_rdre;
   logic        in_read_err;
   logic        same_syn;
   logic        act_correct;
   logic        act_reread;
   logic        act_raw;
   logic        act_fail;
   logic        other_err;
   logic        term;
   logic        abort_now;
   logic [15:0] masks;
   logic [7:0]  err_masked;

   dcep_page_capture u_page (
      .clk        (clk),
      .reset      (reset),
      .page_start (page_start),
      .byte_valid (page_byte_valid),
      .byte_data  (page_byte),
      .key_ok     (page_key_ok),
      .page_done  (pg_done),
      .page_ok    (pg_ok),
      .cache_byte (pg_cache),
      .seg_byte   (pg_seg),
      .recov_byte (pg_recov),
      .retry_byte (pg_retry),
      .drive_byte (pg_drive)
   );

   ////////////////////////////////////////////////////////////////////////////
   // A rejected page leaves the live settings untouched.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cache_reg <= RST_CACHE;
         seg_reg   <= RST_SEG;
         recov_reg <= RST_RECOV;
         retry_reg <= RST_RETRY;
         drive_reg <= RST_DRIVE;
      end else if (pg_done && pg_ok) begin
         cache_reg <= pg_cache;
         seg_reg   <= pg_seg;
         recov_reg <= pg_recov;
         retry_reg <= pg_retry;
         drive_reg <= pg_drive;
      end
   end

   assign cache_on           = cache_reg[B_CACHE];
   assign prefetch_on        = cache_reg[B_CACHE] & cache_reg[B_PREFETCH];
   assign segment_count      = seg_reg;
   assign retry_limit        = retry_reg;
   assign ecc_span           = ECC_SPAN;
   assign auto_read_on       = drive_reg[B_AREAD];
   assign auto_geometry_on   = drive_reg[B_AGEO];
   assign write_back_on      = drive_reg[B_WBB];
   assign read_continuous_on = recov_reg[B_RCONT];
   assign eff_skip           = recov_reg[B_SKIPCOR] & ~read_continuous_on;
   assign eff_imm            = recov_reg[B_IMMECC] & ~read_continuous_on;
   assign eff_rdre           = recov_reg[B_RDREALOC] & ~read_continuous_on;

   ////////////////////////////////////////////////////////////////////////////
   // Read error recovery decision, made in the cycle the media reports.
   always_comb begin
      in_read_err = (state_reg == ST_EXEC) && (cls_reg == CLS_READ) && media_data_err;
      same_syn    = syn_valid_reg && (media_syndrome == last_syn_reg) &&
                    (media_syndrome != 16'h0000);
      act_correct = 1'b0;
      act_reread  = 1'b0;
      act_raw     = 1'b0;
      act_fail    = 1'b0;
      if (in_read_err && !read_continuous_on) begin
         if (eff_skip) begin
            act_raw = 1'b1;
         end else if (eff_imm && same_syn && media_correctable) begin
            act_correct = 1'b1;
         end else if (retry_cnt_reg < retry_reg) begin
            act_reread = 1'b1;
         end else if (media_correctable) begin
            act_correct = 1'b1;
         end else begin
            act_fail = 1'b1;
         end
      end
      other_err = (state_reg == ST_EXEC) && (media_write_fault || media_idnf ||
                  media_amnf || media_bbk || media_tk0_fail);
      term      = other_err || act_raw || act_fail;
      abort_now = (cls_reg == CLS_INVALID) || !param_ok_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_valid) begin
               state_next = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (abort_now) begin
               state_next = ST_DONE;
            end else if (write_back_on && buf_pending && cls_reg != CLS_WRITE) begin
               state_next = ST_HOLD;
            end else begin
               state_next = ST_EXEC;
            end
         end
         ST_HOLD: begin
            if (!buf_pending) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (term) begin
               state_next = ST_DONE;
            end else if (media_done) begin
               state_next = ST_DONE;
            end else if (cls_reg == CLS_WRITE && write_back_on && host_data_all_in) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cls_reg      <= CLS_OTHER;
         param_ok_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && cmd_valid) begin
         cls_reg      <= cmd_class;
         param_ok_reg <= cmd_param_ok;
      end
   end

   assign cmd_ready        = (state_reg == ST_IDLE);
   assign host_data_accept = (state_reg == ST_EXEC) && (cls_reg == CLS_WRITE);

   ////////////////////////////////////////////////////////////////////////////
   // Retry bookkeeping restarts with every command and every good sector.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         retry_cnt_reg <= 8'h00;
         last_syn_reg  <= 16'h0000;
         syn_valid_reg <= 1'b0;
      end else if (state_reg == ST_CHECK || (state_reg == ST_EXEC && media_sector_ok)) begin
         retry_cnt_reg <= 8'h00;
         syn_valid_reg <= 1'b0;
      end else if (in_read_err && !read_continuous_on) begin
         last_syn_reg  <= media_syndrome;
         syn_valid_reg <= 1'b1;
         if (act_reread) begin
            retry_cnt_reg <= retry_cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reread_req  <= 1'b0;
         correct_req <= 1'b0;
         deliver_raw <= 1'b0;
         realloc_req <= 1'b0;
      end else begin
         reread_req  <= act_reread;
         correct_req <= act_correct;
         deliver_raw <= act_raw || act_fail;
         realloc_req <= (eff_rdre && in_read_err && same_syn) ||
                        (eff_rdre && act_fail && drive_reg[B_REUNC]) ||
                        (state_reg == ST_EXEC && media_write_fault &&
                         recov_reg[B_WRREALOC]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         err_acc_reg  <= 8'h00;
         corr_acc_reg <= 1'b0;
         dwf_acc_reg  <= 1'b0;
      end else if (state_reg == ST_CHECK) begin
         err_acc_reg         <= 8'h00;
         err_acc_reg[E_ABRT] <= abort_now;
         corr_acc_reg        <= 1'b0;
         dwf_acc_reg         <= 1'b0;
      end else if (state_reg == ST_EXEC) begin
         err_acc_reg[E_UNC]  <= err_acc_reg[E_UNC] | act_raw | act_fail;
         err_acc_reg[E_IDNF] <= err_acc_reg[E_IDNF] | media_idnf;
         err_acc_reg[E_AMNF] <= err_acc_reg[E_AMNF] | media_amnf;
         err_acc_reg[E_BBK]  <= err_acc_reg[E_BBK] | media_bbk;
         err_acc_reg[E_TK0]  <= err_acc_reg[E_TK0] | media_tk0_fail;
         corr_acc_reg        <= corr_acc_reg | act_correct;
         dwf_acc_reg         <= dwf_acc_reg | media_write_fault;
      end
   end

   assign masks      = dcep_masks(cls_reg);
   assign err_masked = err_acc_reg & masks[15:8];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmd_done   <= 1'b0;
         error_out  <= 8'h00;
         status_out <= 8'h00;
      end else begin
         cmd_done <= (state_reg == ST_DONE);
         if (state_reg == ST_DONE) begin
            error_out          <= err_masked;
            status_out         <= 8'h00;
            status_out[S_DRDY] <= drive_ready & masks[S_DRDY];
            status_out[S_DWF]  <= dwf_acc_reg & masks[S_DWF];
            status_out[S_DSC]  <= seek_complete & masks[S_DSC];
            status_out[S_CORR] <= corr_acc_reg & masks[S_CORR];
            status_out[S_ERR]  <= (|err_masked) | (dwf_acc_reg & masks[S_DWF]) |
                                  ((cls_reg == CLS_DIAG) & diag_fail);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_prefetch_gate;
      @(posedge clk) disable iff (reset)
      pg_done && pg_ok && !pg_cache[B_CACHE] |=> !prefetch_on && !cache_on;
   endproperty
   a_prefetch_gate: assert property (p_prefetch_gate)
      else $error("prefetch active while caching is off");

   property p_keep_rejected;
      @(posedge clk) disable iff (reset)
      pg_done && !pg_ok |=> $stable({cache_reg, seg_reg, recov_reg, retry_reg, drive_reg});
   endproperty
   a_keep_rejected: assert property (p_keep_rejected)
      else $error("rejected page changed the settings");

   property p_abort;
      @(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && cmd_valid && cmd_class == CLS_INVALID
         |-> ##3 cmd_done && error_out[E_ABRT];
   endproperty
   a_abort: assert property (p_abort)
      else $error("invalid command not aborted in three cycles");

   property p_hold_enter;
      @(posedge clk) disable iff (reset)
      state_reg == ST_CHECK && !abort_now && write_back_on && buf_pending &&
         cls_reg != CLS_WRITE |=> state_reg == ST_HOLD;
   endproperty
   a_hold_enter: assert property (p_hold_enter)
      else $error("command not held behind buffered writes");

   property p_hold_stay;
      @(posedge clk) disable iff (reset)
      state_reg == ST_HOLD && buf_pending |=> state_reg == ST_HOLD;
   endproperty
   a_hold_stay: assert property (p_hold_stay)
      else $error("held command released before flush");

   property p_wb_done;
      @(posedge clk) disable iff (reset)
      state_reg == ST_EXEC && !term && cls_reg == CLS_WRITE && write_back_on &&
         host_data_all_in |=> state_reg == ST_DONE ##1 cmd_done;
   endproperty
   a_wb_done: assert property (p_wb_done)
      else $error("buffered write did not complete");

   property p_term;
      @(posedge clk) disable iff (reset)
      state_reg == ST_EXEC && term |=> state_reg == ST_DONE ##1 cmd_done && (status_out[S_ERR]
         || cls_reg == CLS_DIAG);
   endproperty
   a_term: assert property (p_term)
      else $error("command kept running after an error");

   property p_write_report;
      @(posedge clk) disable iff (reset)
      cmd_done && cls_reg == CLS_WRITE |-> !error_out[E_UNC] && !status_out[S_CORR];
   endproperty
   a_write_report: assert property (p_write_report)
      else $error("write reported a data correction condition");

   property p_retry_bound;
      @(posedge clk) disable iff (reset)
      reread_req |-> $past(retry_cnt_reg) < $past(retry_reg);
   endproperty
   a_retry_bound: assert property (p_retry_bound)
      else $error("reread beyond the retry count");

   property p_continuous;
      @(posedge clk) disable iff (reset)
      in_read_err && read_continuous_on
         |=> !reread_req && !correct_req && !realloc_req && !deliver_raw;
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("recovery started in read continuous mode");

   property p_skip;
      @(posedge clk) disable iff (reset)
      in_read_err && eff_skip |=> deliver_raw && !correct_req ##2 error_out[E_UNC];
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip correction did not deliver raw data");

endmodule : dcep_config_policy

/* File: bench/dcep_host_model.sv */
`timescale 1ns/1ps
module dcep_host_model (
   input  wire logic clk,
   output logic      page_start,
   output logic      page_byte_valid,
   output logic [7:0] page_byte,
   output logic      page_key_ok
);
   initial begin
      page_start = 1'b0;
      page_byte_valid = 1'b0;
      page_byte = 8'h00;
      page_key_ok = 1'b0;
   end
   ////////////////////////////////////////
   task automatic send_page(input logic [7:0] b32, b33, b36, b37, b39, input logic key);
      logic [7:0] v;
      @(negedge clk);
      page_start <= 1'b1;
      page_key_ok <= key;
      for (int i = 0; i < 512; i++) begin
         case (i)
            32: v = b32;
            33: v = b33;
            36: v = b36;
            37: v = b37;
            38: v = 8'hff;
            39: v = b39;
            default: v = 8'h00;
         endcase
         @(negedge clk);
         page_start <= 1'b0;
         page_byte_valid <= 1'b1;
         page_byte <= v;
      end
      @(negedge clk);
      page_byte_valid <= 1'b0;
      // Released bus shows the inverse so a stale byte is never mistaken for data.
      page_byte <= ~page_byte;
      repeat (3) @(negedge clk);
   endtask : send_page
endmodule : dcep_host_model

/* File: bench/dcep_config_policy_tb_top.sv */
`timescale 1ns/1ps
module dcep_config_policy_tb_top import dcep_pkg::*;;
   logic clk, reset, cmd_valid, cmd_param_ok, cmd_ready, cmd_done, drive_ready;
   logic seek_complete, diag_fail, buf_pending, host_data_all_in, media_done;
   logic media_data_err, media_write_fault, media_correctable, host_data_accept;
   logic reread_req, deliver_raw, realloc_req, cache_on, prefetch_on, auto_read_on;
   logic auto_geometry_on, write_back_on, read_continuous_on, correct_req, media_idnf;
   logic page_start, page_byte_valid, page_key_ok;
   logic [7:0] page_byte, error_out, status_out, segment_count, retry_limit, ecc_span;
   logic [15:0] media_syndrome;
   dcep_cls_t cmd_class;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   dcep_host_model HM (.clk, .page_start, .page_byte_valid, .page_byte, .page_key_ok);
   dcep_config_policy DUT (.clk, .reset, .page_start, .page_byte_valid, .page_byte,
      .page_key_ok, .cmd_valid, .cmd_class, .cmd_param_ok, .cmd_ready, .cmd_done,
      .error_out, .status_out, .drive_ready, .seek_complete, .diag_fail, .buf_pending,
      .host_data_all_in, .media_done, .media_data_err, .media_syndrome,
      .media_correctable, .media_sector_ok(1'b0), .media_write_fault,
      .media_idnf, .media_amnf(1'b0), .media_bbk(1'b0), .media_tk0_fail(1'b0),
      .host_data_accept, .reread_req, .correct_req, .deliver_raw, .realloc_req,
      .cache_on, .prefetch_on, .segment_count, .retry_limit, .ecc_span, .auto_read_on,
      .auto_geometry_on, .write_back_on, .read_continuous_on);
   ////////////////////////////////////////
   task automatic close_out();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cfg(input logic [7:0] f, sg, rt);
      chk({2'b00, cache_on, prefetch_on, auto_read_on, auto_geometry_on, write_back_on,
         read_continuous_on}, f);
      chk(segment_count, sg);
      chk(retry_limit, rt);
      chk(ecc_span, 8'h10);
   endtask : cfg
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   // Event codes: 1 data error, 2 media done, 3 host data in, 4 write fault,
   // 5 the same data error twice in a row, 6 ID not found.
   task automatic run(input dcep_cls_t c, input logic ok, input int ev,
                      input logic [3:0] rq, input logic [7:0] ee, es);
      int n;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_class = c;
      cmd_param_ok = ok;
      @(negedge clk);
      cmd_valid = 1'b0;
      chk({7'h00, cmd_ready}, 8'h00);
      if (buf_pending && c != CLS_WRITE) begin
         repeat (2) @(negedge clk);
         pulse(media_done);
         repeat (5) begin
            chk({7'h00, cmd_done}, 8'h00);
            @(negedge clk);
         end
         buf_pending = 1'b0;
      end
      if (ev != 0) begin
         repeat (2) @(negedge clk);
         if (c == CLS_WRITE) chk({7'h00, host_data_accept}, 8'h01);
         if (ev == 5) begin
            media_data_err = 1'b1;
            @(negedge clk);
         end
         if (ev == 1 || ev == 5) pulse(media_data_err);
         if (ev == 2) pulse(media_done);
         if (ev == 3) pulse(host_data_all_in);
         if (ev == 4) pulse(media_write_fault);
         if (ev == 6) pulse(media_idnf);
         if (ev == 1 || ev >= 4) begin
            chk({4'h0, correct_req, reread_req, deliver_raw, realloc_req}, {4'h0, rq});
            pulse(media_done);
         end
      end
      for (n = 0; n < 12 && cmd_done !== 1'b1; n++) @(negedge clk);
      chk({7'h00, cmd_done}, 8'h01);
      chk(error_out, ee);
      chk(status_out, es);
   endtask : run
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      reset = 1'b1;
      {cmd_valid, diag_fail, buf_pending, host_data_all_in} = 4'h0;
      {media_done, media_data_err, media_write_fault, media_idnf} = 4'h0;
      {cmd_param_ok, drive_ready, seek_complete, media_correctable} = 4'hf;
      cmd_class = CLS_READ;
      media_syndrome = 16'h1234;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      cfg(8'h36, 8'h01, 8'h08);
      run(CLS_READ, 1'b1, 1, 4'b0100, 8'h00, 8'h50);
      run(CLS_INVALID, 1'b1, 0, 4'b0000, 8'h04, 8'h51);
      run(CLS_READ, 1'b0, 0, 4'b0000, 8'h04, 8'h51);
      diag_fail = 1'b1;
      run(CLS_DIAG, 1'b1, 2, 4'b0000, 8'h00, 8'h01);
      diag_fail = 1'b0;
      run(CLS_RECAL, 1'b1, 2, 4'b0000, 8'h00, 8'h50);
      run(CLS_WRITE, 1'b1, 3, 4'b0000, 8'h00, 8'h50);
      buf_pending = 1'b1;
      run(CLS_WRITE, 1'b1, 3, 4'b0000, 8'h00, 8'h50);
      run(CLS_READ, 1'b1, 2, 4'b0000, 8'h00, 8'h50);
      run(CLS_WRITE, 1'b1, 4, 4'b0001, 8'h00, 8'h71);
      HM.send_page(8'h02, 8'h04, 8'hff, 8'h03, 8'hff, 1'b1);
      cfg(8'h0f, 8'h04, 8'h03);
      run(CLS_READ, 1'b1, 1, 4'b0000, 8'h00, 8'h50);
      HM.send_page(8'h03, 8'h07, 8'h00, 8'h09, 8'h00, 1'b0);
      cfg(8'h0f, 8'h04, 8'h03);
      HM.send_page(8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 1'b1);
      cfg(8'h20, 8'h01, 8'h02);
      run(CLS_READ, 1'b1, 1, 4'b0010, 8'h40, 8'h51);
      HM.send_page(8'h01, 8'h01, 8'h48, 8'h03, 8'h00, 1'b1);
      run(CLS_READ, 1'b1, 5, 4'b1001, 8'h00, 8'h54);
      run(CLS_WRITE, 1'b1, 6, 4'b0000, 8'h10, 8'h51);
      close_out();
   end
endmodule : dcep_config_policy_tb_top
